//--- logic/vplf_top.v
// VPW link front end: power modes, wakeup, loopback, receive filter, length.
`timescale 1ns/1ps
`include "vplf_regs.vh"
module vplf_top #(
  parameter IDLE_CYC = `VPLF_IDLE_US * `VPLF_CLK_MHZ,
  parameter MUX_DIV  = `VPLF_MUX_DIV
) (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        arst_n_in,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_awaddr_in,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  // AXI4-Lite write response
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  output reg  [1:0]  s_axi_bresp_out,
  // AXI4-Lite read
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  input  wire [31:0] s_axi_araddr_in,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  // CPU power events
  input  wire        cpu_wait_in,
  input  wire        cpu_stop_in,
  // Protocol handler side
  input  wire        tx_bit_in,
  input  wire        rx_byte_done_in,
  input  wire        eof_seen_in,
  output reg         rx_filtered_out,
  // Transceiver pins
  output reg         tx_digital_out,
  input  wire        rx_digital_in,
  // Power and interrupts
  output reg         clocks_run_out,
  output reg         wakeup_nmi_out,
  output reg         irq_out
);

  // ****************************************************************
  // Constants and declarations
  // ****************************************************************
  localparam [2:0] PM_RUN  = 3'b001;
  localparam [2:0] PM_WAIT = 3'b010;
  localparam [2:0] PM_STOP = 3'b100;
  localparam integer MIN_SYM_CYC = `VPLF_MIN_SYM_US * `VPLF_CLK_MHZ;
  localparam integer HALF_DIV = MUX_DIV / 2;

  reg        wcm_q;
  reg [1:0]  ctrl2_q;
  reg [4:0]  status_q;
  reg [4:0]  mask_q;
  reg [7:0]  data_q;
  reg        data_loaded_q;
  reg [2:0]  pm_q;
  reg        rx_prev_q;
  reg        analog_loop_select_prev_q;
  reg        await_idle_q;
  reg [15:0] idle_cnt_q;
  reg [7:0]  div_q;
  reg        sample_q;
  reg [3:0]  filt_cnt_q;
  reg        filt_prev_q;
  reg [15:0] sym_cnt_q;
  reg [3:0]  byte_cnt_q;
  reg        aw_held_q;
  reg        w_held_q;
  reg [4:0]  aw_addr_q;
  reg [7:0]  w_byte_q;
  reg        w_lane_q;

  wire       digital_loop_select = ctrl2_q[`VPLF_CTRL2_DIGITAL_LOOP_SELECT];
  wire       analog_loop_select = ctrl2_q[`VPLF_CTRL2_ANALOG_LOOP_SELECT];
  wire       low_power = ~pm_q[0];
  wire       rx_src = digital_loop_select ? tx_bit_in : rx_digital_in;
  wire       rx_rise = rx_src & ~rx_prev_q;
  wire       wake_ok = ~digital_loop_select & ~analog_loop_select;
  wire       filt_run = ~pm_q[2];
  wire       tick_rise = filt_run && (div_q == 8'h00);
  wire       tick_fall = filt_run && (div_q == HALF_DIV[7:0]);
  wire       wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid_out;
  wire       rd_fire = s_axi_arvalid_in & s_axi_arready_out;
  wire [4:0] st_clr = (wr_fire && aw_addr_q == `VPLF_OFF_STATUS && w_lane_q)
                      ? w_byte_q[4:0] : 5'h00;
  reg  [4:0] st_set;

  // Picks the most urgent pending condition for the state vector.
  function [3:0] sv_code;
    input [4:0] st;
    begin
      if (st[`VPLF_ST_STOPWAKE]) begin
        sv_code = `VPLF_SV_STOPWAKE;
      end else if (st[`VPLF_ST_WAITWAKE]) begin
        sv_code = `VPLF_SV_WAITWAKE;
      end else if (st[`VPLF_ST_INVSYM]) begin
        sv_code = `VPLF_SV_INVSYM;
      end else if (st[`VPLF_ST_OVERLEN]) begin
        sv_code = `VPLF_SV_OVERLEN;
      end else if (st[`VPLF_ST_EOF]) begin
        sv_code = `VPLF_SV_EOF;
      end else begin
        sv_code = `VPLF_SV_NONE;
      end
    end
  endfunction

  // ****************************************************************
  // Power mode state machine
  // ****************************************************************
  // Mode changes never touch the software registers, so contents survive.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pm_q      <= PM_RUN;
      rx_prev_q <= 1'b0;
    end else begin
      rx_prev_q <= rx_src;
      case (pm_q)
        PM_RUN: begin
          if (cpu_wait_in) begin
            pm_q <= wcm_q ? PM_STOP : PM_WAIT;
          end else if (cpu_stop_in) begin
            pm_q <= wcm_q ? PM_STOP : PM_WAIT;
          end
        end
        PM_WAIT, PM_STOP: begin
          if (rx_rise && wake_ok) begin
            pm_q <= PM_RUN;
          end
        end
        default: pm_q <= PM_RUN;
      endcase
    end
  end

  // ****************************************************************
  // Receive digital filter
  // ****************************************************************
  // The filter clock is a divided tick; rise samples, mid-period counts.
  // It keeps running in wait mode so the waking message is not lost.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q           <= 8'h00;
      sample_q        <= 1'b0;
      filt_cnt_q      <= `VPLF_FILT_MIN;
      rx_filtered_out <= 1'b0;
    end else begin
      if (filt_run) begin
        div_q <= (div_q == MUX_DIV[7:0] - 8'h01) ? 8'h00 : div_q + 8'h01;
      end
      if (tick_rise) begin
        sample_q <= rx_src;
      end
      if (tick_fall) begin
        if (sample_q && filt_cnt_q != `VPLF_FILT_MAX) begin
          filt_cnt_q <= filt_cnt_q + 4'h1;
        end else if (!sample_q && filt_cnt_q != `VPLF_FILT_MIN) begin
          filt_cnt_q <= filt_cnt_q - 4'h1;
        end
        // Latch flips only at an end point, giving 15 to 16 tick delay.
        if (sample_q && filt_cnt_q == `VPLF_FILT_MAX - 4'h1) begin
          rx_filtered_out <= 1'b1;
        end else if (!sample_q && filt_cnt_q == `VPLF_FILT_MIN + 4'h1) begin
          rx_filtered_out <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Symbol width, message length and idle detection
  // ****************************************************************
  // Pulses that survive the filter in run mode but are shorter than any symbol are
  // flagged; the length counter counts byte completions and clears at end of frame.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      filt_prev_q  <= 1'b0;
      sym_cnt_q    <= 16'h0000;
      byte_cnt_q   <= 4'h0;
      analog_loop_select_prev_q <= 1'b0;
      await_idle_q <= 1'b0;
      idle_cnt_q   <= 16'h0000;
    end else begin
      filt_prev_q  <= rx_filtered_out;
      analog_loop_select_prev_q <= analog_loop_select;
      if (rx_filtered_out != filt_prev_q) begin
        sym_cnt_q <= 16'h0000;
      end else if (sym_cnt_q != 16'hFFFF) begin
        sym_cnt_q <= sym_cnt_q + 16'h0001;
      end
      if (eof_seen_in) begin
        byte_cnt_q <= 4'h0;
      end else if (rx_byte_done_in && byte_cnt_q != 4'hF) begin
        byte_cnt_q <= byte_cnt_q + 4'h1;
      end
      // After analog loop ends, hold off until the bus rests passive.
      if (analog_loop_select_prev_q && !analog_loop_select) begin
        await_idle_q <= 1'b1;
        idle_cnt_q   <= 16'h0000;
      end else if (await_idle_q) begin
        if (rx_filtered_out) begin
          idle_cnt_q <= 16'h0000;
        end else if (idle_cnt_q == IDLE_CYC[15:0] - 16'h0001) begin
          await_idle_q <= 1'b0;
        end else begin
          idle_cnt_q <= idle_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // Event status and interrupts
  // ****************************************************************
  // Gathers the hardware events that set sticky status bits.
  always @* begin
    st_set = 5'h00;
    st_set[`VPLF_ST_STOPWAKE] = pm_q[2] & rx_rise & wake_ok;
    st_set[`VPLF_ST_WAITWAKE] = pm_q[1] & rx_rise & wake_ok;
    st_set[`VPLF_ST_INVSYM]   = (rx_filtered_out != filt_prev_q) &&
                                (sym_cnt_q < MIN_SYM_CYC[15:0]) &&
                                pm_q[0];
    st_set[`VPLF_ST_OVERLEN]  = rx_byte_done_in &&
                                (byte_cnt_q >= `VPLF_MAX_BYTES);
    st_set[`VPLF_ST_EOF]      = eof_seen_in;
  end

  // Set wins over a same-cycle write-one clear so no event is lost.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_q       <= 5'h00;
      irq_out        <= 1'b0;
      wakeup_nmi_out <= 1'b0;
      clocks_run_out <= 1'b1;
      tx_digital_out <= 1'b0;
    end else begin
      status_q       <= (status_q & ~st_clr) | st_set;
      irq_out        <= |(status_q & mask_q &
                          ~(5'h01 << `VPLF_ST_STOPWAKE));
      wakeup_nmi_out <= status_q[`VPLF_ST_STOPWAKE];
      clocks_run_out <= ~pm_q[2];
      // Passive in digital loop, while waiting for idle, or in any low-power mode.
      tx_digital_out <= (digital_loop_select | low_power | await_idle_q) ?
                        1'b0 : tx_bit_in;
    end
  end

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  // Address and data are taken in either order; the response waits for
  // both. Only byte lane 0 carries fields, higher lanes are ignored.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `VPLF_RESP_OKAY;
      aw_held_q         <= 1'b0;
      w_held_q          <= 1'b0;
      aw_addr_q         <= 5'h00;
      w_byte_q          <= 8'h00;
      w_lane_q          <= 1'b0;
      wcm_q             <= `VPLF_CTRL1_RST;
      ctrl2_q           <= `VPLF_CTRL2_RST;
      mask_q            <= `VPLF_MASK_RST;
      data_q            <= `VPLF_DATA_RST;
      data_loaded_q     <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_q         <= 1'b1;
        // Any upper address bit marks the write off-map; 5'h1F decodes to
        // no register and so answers with an error.
        aw_addr_q         <= (|s_axi_awaddr_in[31:5]) ? 5'h1F :
                             {s_axi_awaddr_in[4:2], 2'b00};
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_q         <= 1'b1;
        w_byte_q         <= s_axi_wdata_in[7:0];
        w_lane_q         <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      if (rx_byte_done_in) begin
        data_loaded_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q        <= 1'b0;
        w_held_q         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= `VPLF_RESP_OKAY;
        case (aw_addr_q)
          `VPLF_OFF_CTRL1: if (w_lane_q) wcm_q <= w_byte_q[0];
          `VPLF_OFF_CTRL2: if (w_lane_q) ctrl2_q <= w_byte_q[1:0];
          `VPLF_OFF_MASK:  if (w_lane_q) mask_q <= w_byte_q[4:0];
          `VPLF_OFF_DATA: begin
            if (w_lane_q) begin
              data_q        <= w_byte_q;
              data_loaded_q <= 1'b1;
            end
          end
          `VPLF_OFF_STATUS, `VPLF_OFF_SVR, `VPLF_OFF_FILTER,
          `VPLF_OFF_POWER: s_axi_bresp_out <= `VPLF_RESP_OKAY;
          default: s_axi_bresp_out <= `VPLF_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  // One read at a time; the answer comes one cycle after the address.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `VPLF_RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rresp_out   <= `VPLF_RESP_OKAY;
        case ((|s_axi_araddr_in[31:5]) ? 5'h1F :
              {s_axi_araddr_in[4:2], 2'b00})
          `VPLF_OFF_CTRL1:  s_axi_rdata_out <= {31'h0, wcm_q};
          `VPLF_OFF_CTRL2:  s_axi_rdata_out <= {30'h0, ctrl2_q};
          `VPLF_OFF_SVR:    s_axi_rdata_out <= {28'h0, sv_code(status_q)};
          `VPLF_OFF_STATUS: s_axi_rdata_out <= {27'h0, status_q};
          `VPLF_OFF_MASK:   s_axi_rdata_out <= {27'h0, mask_q};
          `VPLF_OFF_FILTER: s_axi_rdata_out <= {26'h0, rx_src,
                                                rx_filtered_out, filt_cnt_q};
          `VPLF_OFF_POWER:  s_axi_rdata_out <= {16'h0, `VPLF_NMI_VECTOR,
                                                3'h0, await_idle_q,
                                                byte_cnt_q[0], pm_q};
          `VPLF_OFF_DATA:   s_axi_rdata_out <= {23'h0, data_loaded_q,
                                                data_q};
          default: begin
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `VPLF_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

endmodule // vplf_top

//--- logic/vplf_regs.vh
// Register map, field positions, reset values and timing for the VPW link front end.
`ifndef VPLF_REGS_VH
`define VPLF_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VPLF_OFF_CTRL1   5'h00
`define VPLF_OFF_CTRL2   5'h04
`define VPLF_OFF_SVR     5'h08
`define VPLF_OFF_STATUS  5'h0C
`define VPLF_OFF_MASK    5'h10
`define VPLF_OFF_FILTER  5'h14
`define VPLF_OFF_POWER   5'h18
`define VPLF_OFF_DATA    5'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define VPLF_CTRL1_WCM    0
`define VPLF_CTRL2_DIGITAL_LOOP_SELECT  0
`define VPLF_CTRL2_ANALOG_LOOP_SELECT  1
`define VPLF_ST_STOPWAKE  0
`define VPLF_ST_WAITWAKE  1
`define VPLF_ST_INVSYM    2
`define VPLF_ST_OVERLEN   3
`define VPLF_ST_EOF       4
`define VPLF_ST_W         5

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define VPLF_CTRL1_RST    1'b0
`define VPLF_CTRL2_RST    2'b00
`define VPLF_MASK_RST     5'h00
`define VPLF_DATA_RST     8'h00
`define VPLF_NMI_VECTOR   8'h20
`define VPLF_SV_NONE      4'h0
`define VPLF_SV_EOF       4'h1
`define VPLF_SV_OVERLEN   4'h2
`define VPLF_SV_INVSYM    4'h3
`define VPLF_SV_WAITWAKE  4'h4
`define VPLF_SV_STOPWAKE  4'h5
`define VPLF_MAX_BYTES    4'hC
`define VPLF_FILT_MAX     4'hF
`define VPLF_FILT_MIN     4'h0
`define VPLF_RESP_OKAY    2'b00
`define VPLF_RESP_SLVERR  2'b10

// ****************************************************************
// Timing
// ****************************************************************
`define VPLF_CLK_MHZ      100
`define VPLF_IDLE_US      300
`define VPLF_MIN_SYM_US   34
`define VPLF_MUX_DIV      96

`endif

//--- test/vplf_checker_asserts.sv
// Port-level assertions for the VPW link front end.
`timescale 1ns/1ps
module vplf_checker #(
  parameter MUX_DIV = 96
) (
  // Clock and reset
  input wire       clk_sys_in,
  input wire       arst_n_in,
  // Watched ports
  input wire       cpu_wait_in,
  input wire       cpu_stop_in,
  input wire       tx_bit_in,
  input wire       rx_digital_in,
  input wire       tx_digital_out,
  input wire       rx_filtered_out,
  input wire       clocks_run_out,
  input wire       wakeup_nmi_out,
  input wire       s_axi_bvalid_out,
  input wire       s_axi_bready_in,
  input wire [1:0] s_axi_bresp_out
);
  localparam int RISE_MIN = 13 * MUX_DIV;
  localparam int SETTLE = 17 * MUX_DIV;
  reg  [15:0] hi_q;
  reg  [15:0] lo_q;
  reg  [15:0] run_hi_q;
  reg  [15:0] run_lo_q;
  wire        src_any = rx_digital_in | tx_bit_in;
  wire        src_all = rx_digital_in & tx_bit_in;
  // Either pin may feed the filter, so the lower bounds count the loosest
  // view of the source and the settle bounds the strictest one.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
      run_hi_q <= 16'h0000;
      run_lo_q <= 16'h0000;
    end else begin
      hi_q <= rx_filtered_out ? 16'h0000 : hi_q + {15'h0000, src_any};
      lo_q <= !rx_filtered_out ? 16'h0000 : lo_q + {15'h0000, !src_all};
      run_hi_q <= (src_all && clocks_run_out) ?
                  run_hi_q + {15'h0000, run_hi_q < SETTLE} : 16'h0000;
      run_lo_q <= (!src_any && clocks_run_out) ?
                  run_lo_q + {15'h0000, run_lo_q < SETTLE} : 16'h0000;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  mode_entry_a: assert property (
    $fell(clocks_run_out) |-> $past(cpu_wait_in || cpu_stop_in) ||
      $past(cpu_wait_in || cpu_stop_in, 2))
    else $error("clocks halted without a CPU power request");
  stop_wake_nmi_a: assert property (
    $rose(clocks_run_out) |-> ##[0:2] wakeup_nmi_out)
    else $error("stop wake gave no wakeup interrupt");
  nmi_cause_a: assert property (
    $rose(wakeup_nmi_out) |-> !$past(clocks_run_out, 2))
    else $error("wakeup interrupt outside stop mode");
  stop_quiet_a: assert property (
    !clocks_run_out && $past(!clocks_run_out) |-> !tx_digital_out)
    else $error("transmit active in stop mode");
  tx_source_a: assert property (
    tx_digital_out |-> $past(tx_bit_in))
    else $error("transmit pin active without a transmit bit");
  filt_rise_a: assert property (
    $rose(rx_filtered_out) |-> hi_q >= RISE_MIN)
    else $error("filtered output rose too early");
  filt_fall_a: assert property (
    $fell(rx_filtered_out) |-> lo_q >= RISE_MIN)
    else $error("filtered output fell too early");
  settle_high_a: assert property (
    run_hi_q == SETTLE |-> rx_filtered_out)
    else $error("filtered output late to rise");
  settle_low_a: assert property (
    run_lo_q == SETTLE |-> !rx_filtered_out)
    else $error("filtered output late to fall");
  bresp_hold_a: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before taken");
  cover property ($rose(wakeup_nmi_out));
  cover property ($fell(clocks_run_out));
  cover property ($rose(rx_filtered_out));
endmodule // vplf_checker

//--- test/vplf_xcvr_model.sv
// Behavioural off-chip bus transceiver on a wired-or bus.
`timescale 1ns/1ps
module vplf_xcvr_model (
  // Clock
  input  wire clk_sys_in,
  // Link side
  input  wire tx_digital_in,
  output reg  rx_digital_out = 1'h0,
  // Bus and loopback control
  input  wire other_node_in,
  input  wire loop_in
);
  // Active level dominates the bus; in loopback the line driver is cut
  // off, so only our own transmit comes back and the bus is unseen.
  always @(posedge clk_sys_in) begin
    rx_digital_out <= loop_in ? tx_digital_in :
                      (tx_digital_in | other_node_in);
  end
endmodule // vplf_xcvr_model

//--- test/tb_vpw_link_power_loopback_filter.sv
// Self-checking bench for the VPW link front end.
`timescale 1ns/1ps
`include "vplf_regs.vh"
module tb_vpw_link_power_loopback_filter;
  localparam [31:0] A_C1 = {27'h0, `VPLF_OFF_CTRL1};
  localparam [31:0] A_C2 = {27'h0, `VPLF_OFF_CTRL2};
  localparam [31:0] A_SVR = {27'h0, `VPLF_OFF_SVR};
  localparam [31:0] A_ST = {27'h0, `VPLF_OFF_STATUS};
  localparam [31:0] A_MSK = {27'h0, `VPLF_OFF_MASK};
  localparam [31:0] A_FLT = {27'h0, `VPLF_OFF_FILTER};
  localparam [31:0] A_PWR = {27'h0, `VPLF_OFF_POWER};
  localparam [1:0] OK = `VPLF_RESP_OKAY;
  reg clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0;
  reg arv = 1'h0, rry = 1'h0, cwait = 1'h0, cstop = 1'h0, txb = 1'h0;
  reg bdone = 1'h0, eof = 1'h0, other = 1'h0, xloop = 1'h0;
  reg [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0;
  wire awr, wrdy, bv, arr, rv, rxd, txd, rxf, crun, nmi, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg [1:0] bq[$];
  reg [33:0] rq[$];
  integer n_fail = 0, cmp_count = 0, i, k, m, len;
  vplf_top #(.IDLE_CYC(50), .MUX_DIV(8)) dut (
    .clk_sys_in(clk), .arst_n_in(rst_n), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .cpu_wait_in(cwait), .cpu_stop_in(cstop),
    .tx_bit_in(txb), .rx_byte_done_in(bdone), .eof_seen_in(eof),
    .rx_filtered_out(rxf), .tx_digital_out(txd), .rx_digital_in(rxd),
    .clocks_run_out(crun), .wakeup_nmi_out(nmi), .irq_out(irq));
  vplf_xcvr_model u_xcvr (.clk_sys_in(clk), .tx_digital_in(txd),
    .rx_digital_out(rxd), .other_node_in(other), .loop_in(xloop));
  always #5 clk = ~clk;
  // ******
  // Shared tasks
  // ******
  task chk(input [33:0] s, input [33:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task chk1(input s, input e);
    chk({33'h0, s}, {33'h0, e});
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Offers address and data together; each is dropped once taken.
  task wreg(input [31:0] a, input [31:0] d, input [1:0] e);
    integer n;
    begin
      bq.push_back(e);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      n = 0;
      // The first edge must pass before bready can be read back high.
      while (n == 0 || (bry !== 1'h0 && n < 500)) begin
        @(posedge clk);
        n = n + 1;
        if (awv && awr) awv <= 1'h0;
        if (wv && wrdy) wv <= 1'h0;
        if (bv && bry) bry <= 1'h0;
      end
      if (bry !== 1'h0) n_fail = n_fail + 1;
    end
  endtask
  task rreg(input [31:0] a, input [31:0] d, input [1:0] e);
    integer n;
    begin
      rq.push_back({e, d});
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      n = 0;
      while (n == 0 || (rry !== 1'h0 && n < 500)) begin
        @(posedge clk);
        n = n + 1;
        if (arv && arr) arv <= 1'h0;
        if (rv && rry) rry <= 1'h0;
      end
      if (rry !== 1'h0) n_fail = n_fail + 1;
    end
  endtask
  task cpu(input w, input s);
    begin
      cwait <= w;
      cstop <= s;
      tick(1);
      cwait <= 1'h0;
      cstop <= 1'h0;
    end
  endtask
  task bus_pulse(input integer n);
    begin
      other <= 1'h1;
      tick(n);
      other <= 1'h0;
    end
  endtask
  task end_sim;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Responses are compared with the oldest noted expectation.
  always @(posedge clk) begin
    if (bv && bry) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rv && rry) chk({rresp, rdata}, rq.pop_front());
  end
  // A hang ends the run as a failure.
  initial begin
    #300000;
    n_fail = n_fail + 1;
    end_sim;
  end
  initial begin
    k = $urandom(32'h9246);
    tick(3);
    rst_n <= 1'h1;
    tick(1);
    rreg(A_PWR, 32'h2001, OK);
    rreg(A_SVR, 32'h0, OK);
    rreg(32'h40, 32'h0, `VPLF_RESP_SLVERR);
    wreg(32'h40, 32'h1, `VPLF_RESP_SLVERR);
    // Each low-power kind: wait/wait, wait/stop-clock, stop/stop.
    for (k = 0; k < 3; k = k + 1) begin
      wreg(A_C1, k ? 32'h1 : 32'h0, OK);
      wreg(A_MSK, 32'h2, OK);
      // Software sees end of frame before any low-power entry.
      eof <= 1'h1;
      tick(1);
      eof <= 1'h0;
      rreg(A_SVR, 32'h1, OK);
      cpu(k < 2, k == 2);
      tick(3);
      chk1(crun, k == 0);
      rreg(A_PWR, k ? 32'h2004 : 32'h2002, OK);
      bus_pulse(8);
      chk1(crun, 1'h1);
      chk1(nmi, k > 0);
      chk1(irq, k == 0);
      rreg(A_SVR, k ? 32'h5 : 32'h4, OK);
      rreg(A_C1, k ? 32'h1 : 32'h0, OK);
      rreg(A_MSK, 32'h2, OK);
      wreg(A_ST, 32'h1F, OK);
      tick(2);
      chk1(nmi | irq, 1'h0);
    end
    // Either loop bit keeps a sleeping link deaf to the bus.
    for (m = 1; m < 3; m = m + 1) begin
      rreg(A_SVR, 32'h0, OK);
      wreg(A_C2, m, OK);
      cpu(1'h1, 1'h0);
      bus_pulse(8);
      chk1(crun, 1'h0);
      wreg(A_C2, 32'h0, OK);
      bus_pulse(8);
      chk1(nmi, 1'h1);
      wreg(A_ST, 32'h1F, OK);
    end
    // Digital loop: own transmit is heard, pin stays passive.
    wreg(A_C2, 32'h1, OK);
    txb <= 1'h1;
    tick(3);
    chk1(txd, 1'h0);
    tick(150);
    rreg(A_FLT, 32'h3F, OK);
    txb <= 1'h0;
    tick(150);
    rreg(A_FLT, 32'h0, OK);
    // Analog loop passes transmit; leaving it waits for an idle bus.
    wreg(A_C2, 32'h2, OK);
    xloop <= 1'h1;
    txb <= 1'h1;
    tick(3);
    chk1(txd, 1'h1);
    txb <= 1'h0;
    wreg(A_C2, 32'h0, OK);
    xloop <= 1'h0;
    txb <= 1'h1;
    tick(3);
    chk1(txd, 1'h0);
    rreg(A_PWR, 32'h2011, OK);
    i = 0;
    while (txd !== 1'h1 && i < 200) begin
      tick(1);
      i = i + 1;
    end
    chk1(i > 35 && i < 200, 1'h1);
    tick(150);
    chk1(rxf, 1'h1);
    txb <= 1'h0;
    tick(3500);
    wreg(A_ST, 32'h1F, OK);
    // Random glitches shorter than the filter delay never pass.
    for (k = 0; k < 4; k = k + 1) begin
      len = 8 + $urandom % 96;
      bus_pulse(len);
      tick(200);
      chk1(rxf, 1'h0);
    end
    bus_pulse(3500);
    rreg(A_ST, 32'h0, OK);
    tick(3500);
    bus_pulse(300);
    tick(300);
    rreg(A_ST, 32'h4, OK);
    rreg(A_SVR, 32'h3, OK);
    // Twelve bytes pass, end of frame restarts, a thirteenth overruns.
    wreg(A_ST, 32'h1F, OK);
    for (k = 0; k < 26; k = k + 1) begin
      bdone <= (k != 12);
      eof <= (k == 12);
      tick(1);
      bdone <= 1'h0;
      eof <= 1'h0;
      tick(1);
      if (k == 11) rreg(A_ST, 32'h0, OK);
    end
    rreg(A_ST, 32'h18, OK);
    rreg(A_SVR, 32'h2, OK);
    end_sim;
  end
endmodule // tb_vpw_link_power_loopback_filter
bind vplf_top vplf_checker #(.MUX_DIV(MUX_DIV)) u_chk (
  .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
  .cpu_wait_in(cpu_wait_in), .cpu_stop_in(cpu_stop_in),
  .tx_bit_in(tx_bit_in), .rx_digital_in(rx_digital_in),
  .tx_digital_out(tx_digital_out), .rx_filtered_out(rx_filtered_out),
  .clocks_run_out(clocks_run_out), .wakeup_nmi_out(wakeup_nmi_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_bresp_out(s_axi_bresp_out));
